// ==== core/msg_buf_pkg.sv ====
/*
  Message buffer word layout: field positions, word indices, widths.
  Assumes 16-bit buffer words, words 0..6 of one buffer.
*/
package msg_buf_pkg;
  localparam int WORD_W = 16;
  localparam int NUM_WORDS = 7;
  localparam int IDX_W = 3;
  localparam int PAYLOAD_BYTES = 8;
  // word indices
  localparam logic [2:0] W_STD_ID = 3'h0;
  localparam logic [2:0] W_EXT_HI = 3'h1;
  localparam logic [2:0] W_EXT_LO = 3'h2;
  localparam logic [2:0] W_PAY_01 = 3'h3;
  localparam logic [2:0] W_PAY_23 = 3'h4;
  localparam logic [2:0] W_PAY_45 = 3'h5;
  localparam logic [2:0] W_PAY_67 = 3'h6;
  localparam logic [2:0] W_LAST = 3'h6;
  // word 0 fields
  localparam int SID_LSB = 2;
  localparam int SID_MSB = 12;
  localparam int SRR_BIT = 1;
  localparam int IDE_BIT = 0;
  // word 1 fields
  localparam int EIDH_LSB = 0;
  localparam int EIDH_MSB = 11;
  // word 2 fields
  localparam int EIDL_LSB = 10;
  localparam int EIDL_MSB = 15;
  localparam int RTR_BIT = 9;
  localparam int RB1_BIT = 8;
  localparam int RB0_BIT = 4;
  localparam int DLC_LSB = 0;
  localparam int DLC_MSB = 3;
  localparam int EID_SPLIT = 6;
  // frame widths
  localparam int SID_W = 11;
  localparam int EID_W = 18;
  localparam int DLC_W = 4;
  localparam logic [15:0] WORD_ZERO = 16'h0000;

  typedef struct packed {
    logic [SID_W-1:0] standard_identifier;
    logic [EID_W-1:0] extended_identifier;
    logic transmit_extended_flag;
    logic srr;
    logic rtr;
    logic reserved_frame_bit_one;
    logic reserved_frame_bit_zero;
    logic [DLC_W-1:0] dlc;
    logic [PAYLOAD_BYTES-1:0][7:0] payload;
  } frame_t;

  // payload word n (3..6) holds byte 2n-6 low, 2n-5 high
  function automatic logic [WORD_W-1:0] pack_word(input frame_t f, input logic [2:0] idx);
    logic [WORD_W-1:0] w;
    w = WORD_ZERO;
    unique case (idx)
      W_STD_ID: begin
        w[SID_MSB:SID_LSB] = f.standard_identifier;
        w[SRR_BIT] = f.srr;
        w[IDE_BIT] = f.transmit_extended_flag;
      end
      W_EXT_HI: w[EIDH_MSB:EIDH_LSB] = f.extended_identifier[EID_W-1:EID_SPLIT]; // RULE_11
      W_EXT_LO: begin
        w[EIDL_MSB:EIDL_LSB] = f.extended_identifier[EID_SPLIT-1:0]; // RULE_01
        w[RTR_BIT] = f.rtr; // RULE_01
        w[RB1_BIT] = f.reserved_frame_bit_one;
        w[RB0_BIT] = f.reserved_frame_bit_zero;
        w[DLC_MSB:DLC_LSB] = f.dlc; // RULE_04
      end
      W_PAY_01: w = {f.payload[1], f.payload[0]}; // RULE_05 RULE_06
      W_PAY_23: w = {f.payload[3], f.payload[2]}; // RULE_07
      W_PAY_45: w = {f.payload[5], f.payload[4]}; // RULE_08
      W_PAY_67: w = {f.payload[7], f.payload[6]}; // RULE_09 RULE_10
      default: w = WORD_ZERO;
    endcase
    return w;
  endfunction

  function automatic frame_t unpack_word(input frame_t f, input logic [2:0] idx,
                                         input logic [WORD_W-1:0] w);
    frame_t r;
    r = f;
    unique case (idx)
      W_STD_ID: begin
        r.standard_identifier = w[SID_MSB:SID_LSB];
        r.srr = w[SRR_BIT];
        r.transmit_extended_flag = w[IDE_BIT];
      end
      W_EXT_HI: r.extended_identifier[EID_W-1:EID_SPLIT] = w[EIDH_MSB:EIDH_LSB];
      W_EXT_LO: begin
        r.extended_identifier[EID_SPLIT-1:0] = w[EIDL_MSB:EIDL_LSB];
        r.rtr = w[RTR_BIT];
        r.reserved_frame_bit_one = w[RB1_BIT];
        r.reserved_frame_bit_zero = w[RB0_BIT];
        r.dlc = w[DLC_MSB:DLC_LSB];
      end
      W_PAY_01: {r.payload[1], r.payload[0]} = w;
      W_PAY_23: {r.payload[3], r.payload[2]} = w;
      W_PAY_45: {r.payload[5], r.payload[4]} = w;
      W_PAY_67: {r.payload[7], r.payload[6]} = w;
      default: r = f;
    endcase
    return r;
  endfunction
endpackage

// ==== core/msg_buf_if.sv ====
/*
  Word stream between the protocol engine end and the buffer end.
  Assumes both ends share core_clk_i.
*/
`timescale 1ns/1ps
interface msg_buf_if;
  logic [2:0] idx;
  logic [15:0] data;
  logic valid;
  logic ready;
  logic last;

  modport engine (output idx, output data, output valid, output last, input ready);
  modport buffer (input idx, input data, input valid, input last, output ready);
endinterface

// ==== core/msg_word_reg.sv ====
/*
  One stored buffer word with implemented-bit mask.
  Assumes write strobe and data from the same clock domain.
*/
`timescale 1ns/1ps
module msg_word_reg
  import msg_buf_pkg::*;
#(
  parameter logic [15:0] IMPL_MASK = 16'hFFFF
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // write side
  input wire logic wr_i,
  input wire logic [WORD_W-1:0] wdata_i,
  // read side
  output logic [WORD_W-1:0] rdata_o
);
  logic [WORD_W-1:0] word_q;
  logic [WORD_W-1:0] word_d;

  always_comb begin
    word_d = word_q;
    if (wr_i) begin
      word_d = wdata_i & IMPL_MASK;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_q <= WORD_ZERO;
    end else begin
      word_q <= word_d;
    end
  end

  assign rdata_o = word_q;
endmodule // msg_word_reg

// ==== core/msg_buf_ram_end.sv ====
/*
  Buffer end: stores words 0..6 from the stream, readable by software,
  and rebuilds the frame. Assumes the engine end sends word indices.
*/
`timescale 1ns/1ps
module msg_buf_ram_end
  import msg_buf_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // link
  msg_buf_if.buffer link,
  // software read port
  input wire logic [IDX_W-1:0] sw_idx_i,
  output logic [WORD_W-1:0] sw_rdata_o,
  // rebuilt frame
  output frame_t frame_o,
  output logic frame_done_o
);
  localparam logic [15:0] MASK_W2 = 16'hFF1F; // RULE_03
  logic [NUM_WORDS-1:0][WORD_W-1:0] rd;
  logic [WORD_W-1:0] sw_rdata_d;
  logic [WORD_W-1:0] sw_rdata_q;
  frame_t frame_d;
  frame_t frame_q;
  logic done_d;
  logic done_q;
  logic take;

  assign take = link.valid;
  assign link.ready = 1'b1;

  for (genvar g = 0; g < NUM_WORDS; g++) begin : g_word
    msg_word_reg #(
      .IMPL_MASK((g == int'(W_EXT_LO)) ? MASK_W2 : 16'hFFFF)
    ) u_word (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .wr_i(take && (link.idx == 3'(g))),
      .wdata_i(link.data),
      .rdata_o(rd[g])
    );
  end

  always_comb begin
    sw_rdata_d = (sw_idx_i < 3'(NUM_WORDS)) ? rd[sw_idx_i] : WORD_ZERO; // RULE_03
    frame_d = frame_q;
    done_d = 1'b0;
    if (take) begin
      frame_d = unpack_word(frame_q, link.idx, link.data); // RULE_04
      done_d = link.last;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_rdata_q <= WORD_ZERO;
      frame_q <= '0;
      done_q <= 1'b0;
    end else begin
      sw_rdata_q <= sw_rdata_d;
      frame_q <= frame_d;
      done_q <= done_d;
    end
  end

  assign sw_rdata_o = sw_rdata_q;
  assign frame_o = frame_q;
  assign frame_done_o = done_q;
endmodule // msg_buf_ram_end

// ==== core/msg_buf_engine_end.sv ====
/*
  Engine end: packs a frame into message buffer words 0..6 and
  streams them out in order. Assumes the buffer end may stall on ready.
*/
// Function
// RULE_01 - word 2: ext id 5:0 high, remote flag bit9
// RULE_02 - software keeps both reserved bits zero
// RULE_03 - word 2 bits 7..5 read zero
// RULE_04 - length code in word 2 bits 3..0
// RULE_05 - word 3 high byte is payload byte 1
// RULE_06 - word 3 low byte is payload byte 0
// RULE_07 - word 4 holds payload bytes 3 and 2
// RULE_08 - word 5 holds payload bytes 5 and 4
// RULE_09 - word 6 high byte is payload byte 7
// RULE_10 - word 6 low byte is payload byte 6
// RULE_11 - word 1 holds ext id 17..6
// RULE_12 - word 0: std id, substitute and format flags
`timescale 1ns/1ps
module msg_buf_engine_end
  import msg_buf_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // frame request
  input wire logic start_i,
  input frame_t frame_i,
  output logic busy_o,
  output logic reserved_err_o,
  // link
  msg_buf_if.engine link
);
  typedef enum logic [0:0] {IDLE, SEND} state_t;

  // control group
  state_t state_q;
  state_t state_d;
  logic [IDX_W-1:0] idx_q;
  logic [IDX_W-1:0] idx_d;
  logic valid_q;
  logic valid_d;
  logic busy_q;
  logic busy_d;
  logic last_q;
  logic last_d;
  // frame capture group
  frame_t frame_q;
  frame_t frame_d;
  logic err_q;
  logic err_d;
  // word output group
  logic [WORD_W-1:0] data_q;
  logic [WORD_W-1:0] data_d;
  // shared strobes
  logic accept;
  logic step;
  logic finish;

  // index of the word that follows idx
  function automatic logic [IDX_W-1:0] next_idx(input logic [IDX_W-1:0] idx);
    return idx + 3'h1;
  endfunction

  // start taken only while idle: a second one mid-burst is dropped
  assign accept = (state_q == IDLE) && start_i;
  // word handed over, more to follow
  assign step = (state_q == SEND) && link.ready && (idx_q != W_LAST);
  // last word handed over
  assign finish = (state_q == SEND) && link.ready && (idx_q == W_LAST);

  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    valid_d = valid_q;
    unique case (state_q)
      IDLE: begin
        if (accept) begin
          idx_d = W_STD_ID; // RULE_12
          valid_d = 1'b1;
          state_d = SEND;
        end
      end
      SEND: begin
        if (finish) begin
          valid_d = 1'b0;
          state_d = IDLE;
        end else if (step) begin
          idx_d = next_idx(idx_q);
        end
      end
    endcase
    // flags registered so no output is decoded from state
    busy_d = (state_d == SEND);
    last_d = (idx_d == W_LAST);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= IDLE;
      idx_q <= W_STD_ID;
      valid_q <= 1'b0;
      busy_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      valid_q <= valid_d;
      busy_q <= busy_d;
      last_q <= last_d;
    end
  end

  // reserved bits never reach the link; a set one is only reported
  always_comb begin
    frame_d = frame_q;
    err_d = err_q;
    if (accept) begin
      frame_d = frame_i;
      frame_d.reserved_frame_bit_one = 1'b0; // RULE_02
      frame_d.reserved_frame_bit_zero = 1'b0; // RULE_02
      err_d = frame_i.reserved_frame_bit_one | frame_i.reserved_frame_bit_zero;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_q <= '0;
      err_q <= 1'b0;
    end else begin
      frame_q <= frame_d;
      err_q <= err_d;
    end
  end

  // next word packed a cycle ahead so data stands with its index
  always_comb begin
    data_d = data_q;
    if (accept) begin
      data_d = pack_word(frame_d, W_STD_ID); // RULE_12
    end else if (step) begin
      data_d = pack_word(frame_q, next_idx(idx_q)); // RULE_11
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_q <= WORD_ZERO;
    end else begin
      data_q <= data_d;
    end
  end

  assign link.idx = idx_q;
  assign link.data = data_q;
  assign link.valid = valid_q;
  assign link.last = last_q;
  assign busy_o = busy_q;
  assign reserved_err_o = err_q;
endmodule // msg_buf_engine_end

// ==== verification/msg_buf_assertions.sv ====
/* link checker for the buffer word stream.
   assumes one clock, instantiated beside the link interface. */
`timescale 1ns/1ps
module msg_buf_assertions (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // link
  input wire logic [2:0] idx,
  input wire logic [15:0] data,
  input wire logic valid,
  input wire logic ready,
  input wire logic last
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_W0_GAP: assert property (valid && idx == 3'h0 |-> data[15:13] == 3'h0)
    else $error("word 0 top bits set");
  AST_W1_GAP: assert property (valid && idx == 3'h1 |-> data[15:12] == 4'h0)
    else $error("word 1 top bits set");
  AST_W2_GAP: assert property (valid && idx == 3'h2 |-> data[7:5] == 3'h0)
    else $error("word 2 gap bits set");
  AST_RSV_ZERO: assert property (valid && idx == 3'h2 |-> !data[8] && !data[4])
    else $error("reserved bit sent as one");
  AST_FIRST: assert property ($rose(valid) |-> idx == 3'h0)
    else $error("stream not opened by word 0");
  AST_ORDER: assert property (valid && ready && !last |=> valid && idx == $past(idx) + 3'h1)
    else $error("word order broken");
  AST_LAST: assert property (valid |-> last == (idx == 3'h6))
    else $error("last flag off word 6");
  AST_BURST: assert property ($rose(valid) |-> valid [*7] ##1 !valid)
    else $error("burst not seven words");
endmodule // msg_buf_assertions

// ==== verification/can_msg_buffer_word_format_tb.sv ====
/* top bench: engine end and buffer end joined by the link interface.
   assumes the buffer end holds ready high. */
`timescale 1ns/1ps
module can_msg_buffer_word_format_tb;
  import msg_buf_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic start_i = 1'b0;
  frame_t frame_i = '0;
  logic [2:0] sw_idx_i = 3'h0;
  logic busy_o, reserved_err_o, frame_done_o;
  logic [15:0] sw_rdata_o;
  frame_t frame_o, fa, fb;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  msg_buf_if link_if ();
  msg_buf_engine_end msg_buf_engine_end_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .start_i(start_i), .frame_i(frame_i), .busy_o(busy_o),
    .reserved_err_o(reserved_err_o), .link(link_if.engine));
  msg_buf_ram_end msg_buf_ram_end_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .link(link_if.buffer), .sw_idx_i(sw_idx_i), .sw_rdata_o(sw_rdata_o),
    .frame_o(frame_o), .frame_done_o(frame_done_o));
  msg_buf_assertions msg_buf_assertions_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .idx(link_if.idx), .data(link_if.data), .valid(link_if.valid),
    .ready(link_if.ready), .last(link_if.last));

  always #2.5 core_clk_i = ~core_clk_i;

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      $display("[FAIL] %0t run timed out", $time);
      close_out();
    end
  end

  task automatic close_out();
    $display("counts: checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] exp_word(input frame_t f, input int i);
    case (i)
      0: return {3'h0, f.standard_identifier, f.srr, f.transmit_extended_flag};
      1: return {4'h0, f.extended_identifier[17:6]};
      2: return {f.extended_identifier[5:0], f.rtr, 1'b0, 3'h0, 1'b0, f.dlc};
      7: return 16'h0000;
      default: return {f.payload[2*i-5], f.payload[2*i-6]};
    endcase
  endfunction

  task automatic rd(input logic [2:0] i, input frame_t f);
    @(posedge core_clk_i);
    sw_idx_i <= i;
    @(posedge core_clk_i);
    #1;
    check(sw_rdata_o, exp_word(f, int'(i)));
  endtask

  // poke raises a second start while busy, which must be ignored
  task automatic send(input frame_t f, input logic poke);
    int n;
    @(posedge core_clk_i);
    start_i <= 1'b1;
    frame_i <= f;
    @(posedge core_clk_i);
    start_i <= 1'b0;
    frame_i <= ~f;
    n = 0;
    do begin
      @(posedge core_clk_i);
      start_i <= poke && n == 2;
      n++;
      #1;
      if (n == 1) check({15'h0, busy_o}, 16'h0001);
    end while (frame_done_o !== 1'b1 && n < 20);
    check({11'h0, n[4:0]}, 16'h0007);
    check({15'h0, busy_o}, 16'h0000);
  endtask

  task automatic verify(input frame_t f, input logic err);
    frame_t fe;
    fe = f;
    fe.reserved_frame_bit_one = 1'b0;
    fe.reserved_frame_bit_zero = 1'b0;
    check({15'h0, reserved_err_o}, {15'h0, err});
    check({15'h0, frame_o !== fe}, 16'h0000);
    rd(3'h0, fe);
    rd(3'h1, fe);
    rd(3'h2, fe);
    rd(3'h3, fe);
    rd(3'h4, fe);
    rd(3'h5, fe);
    rd(3'h6, fe);
    rd(3'h7, fe);
    $display("test done: frame with id %h", f.standard_identifier);
  endtask

  initial begin
    fa = {11'h5A3, 18'h2C6B5, 5'h1F, 4'hD, 64'h8877665544332211};
    fb = ~fa;
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd(3'h3, '0);
    $display("test done: cleared words after reset");
    send(fa, 1'b0);
    send(fb, 1'b1);
    verify(fb, 1'b0);
    send(fa, 1'b0);
    verify(fa, 1'b1);
    close_out();
  end
endmodule // can_msg_buffer_word_format_tb
